// *** rtl/pac_pkg.sv ***
package pac_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [13:0] IDX_LINE_DRIVER_CLASS  = 14'h0404;
  localparam logic [13:0] IDX_ENERGY_THRESHOLD   = 14'h040D;
  localparam logic [13:0] IDX_DC_CORRECTION      = 14'h0410;
  localparam logic [13:0] IDX_FILTER_CONTROL_ONE = 14'h0416;
  localparam logic [13:0] IDX_EQUALIZER_CONTROL  = 14'h0418;
  localparam logic [13:0] IDX_SUPPLY_OVERRIDE    = 14'h041F;
  localparam logic [13:0] IDX_SUPPLY_STATUS      = 14'h0421;
  localparam logic [13:0] IDX_DEEP_SLEEP_CONTROL = 14'h0428;
  localparam logic [13:0] IDX_DSP_CONFIG_SIX     = 14'h0450;
  localparam logic [13:0] IDX_IDLE_PATTERN_LOW   = 14'h0027;

  // Storage slots
  localparam int unsigned NUM_SLOTS  = 10;
  localparam logic [3:0] SLOT_LDC    = 4'h0;
  localparam logic [3:0] SLOT_THR    = 4'h1;
  localparam logic [3:0] SLOT_DC     = 4'h2;
  localparam logic [3:0] SLOT_FILT   = 4'h3;
  localparam logic [3:0] SLOT_EQ     = 4'h4;
  localparam logic [3:0] SLOT_SOVR   = 4'h5;
  localparam logic [3:0] SLOT_SSTAT  = 4'h6;
  localparam logic [3:0] SLOT_DSC    = 4'h7;
  localparam logic [3:0] SLOT_DSP6   = 4'h8;
  localparam logic [3:0] SLOT_IDLE   = 4'h9;

  // Reset values
  localparam logic [15:0] RST_LDC    = 16'h0020;
  localparam logic [15:0] RST_THR    = 16'h0008;
  localparam logic [15:0] RST_DC     = 16'h2000;
  localparam logic [15:0] RST_FILT   = 16'h0870;
  localparam logic [15:0] RST_EQ     = 16'h0000;
  localparam logic [15:0] RST_SOVR   = 16'h0000;
  localparam logic [15:0] RST_DSC    = 16'h0000;
  localparam logic [15:0] RST_DSP6   = 16'h0141;
  localparam logic [15:0] RST_IDLE   = 16'h0000;

  // Writable bit masks
  localparam logic [15:0] WMASK_ALL  = 16'hFFFF;
  localparam logic [15:0] WMASK_NONE = 16'h0000;
  localparam logic [15:0] WMASK_DSC  = 16'h003F;
  localparam logic [15:0] WMASK_IDLE = 16'h000F;

  // Line driver class codes
  localparam logic [15:0] LDC_CLASS_B = 16'h0020;
  localparam logic [15:0] LDC_CLASS_A = 16'h0024;

  // Field positions
  localparam int unsigned THR_LSB = 0;
  localparam int unsigned DC_FIXED_BIT = 14;
  localparam int unsigned FILT_LSB = 8;
  localparam int unsigned EQ_LSB = 8;
  localparam int unsigned SOVR_CORE_BIT = 12;
  localparam int unsigned SOVR_IO_LSB = 10;
  localparam int unsigned SST_CORE_BIT = 2;
  localparam int unsigned SST_IO_LSB = 0;
  localparam int unsigned DSC_IDLE_MSB_BIT = 5;
  localparam int unsigned DSC_IDLE_EN_BIT = 4;
  localparam int unsigned DSC_FAST_EXIT_BIT = 3;
  localparam int unsigned DSC_DEEP_EN_BIT = 2;
  localparam int unsigned DSP6_EQ_BYPASS_BIT = 13;
  localparam logic [1:0] IO_LEVEL_3V3 = 2'h3;
  localparam logic [1:0] IO_FORCE_3V3 = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: exit durations in ms at a 25 MHz clock
  localparam longint unsigned CLOCK_HZ        = 64'd25000000;
  localparam longint unsigned EXIT_FAST_MS    = 64'd50;
  localparam longint unsigned EXIT_SLOW_MS    = 64'd100;
  localparam longint unsigned EXIT_FAST_CYCLES = EXIT_FAST_MS * CLOCK_HZ / 64'd1000;
  localparam longint unsigned EXIT_SLOW_CYCLES = EXIT_SLOW_MS * CLOCK_HZ / 64'd1000;

  // Deep sleep sequencer states
  typedef enum logic [1:0] {
    PAC_AWAKE  = 2'b00,
    PAC_ASLEEP = 2'b01,
    PAC_WAKING = 2'b10
  } pac_sleep_state_t;

  // Analog configuration driven into the front end
  typedef struct packed {
    logic       class_a;
    logic [4:0] energy_threshold;
    logic       fixed_dc;
    logic [4:0] filter_cutoff;
    logic [5:0] equalizer;
    logic       core_force_3v3;
    logic       io_force_3v3;
    logic       eq_cal_bypass;
  } pac_analog_cfg_t;

  // Detected supply levels
  typedef struct packed {
    logic       core_3v3;
    logic [1:0] io_level;
  } pac_supply_t;

endpackage

// *** rtl/pac_regs.sv ***
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module pac_regs #(
  parameter int unsigned ADDR_W      = 16,
  parameter int unsigned EXIT_FAST_N = int'(pac_pkg::EXIT_FAST_CYCLES),
  parameter int unsigned EXIT_SLOW_N = int'(pac_pkg::EXIT_SLOW_CYCLES)
) (
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  // AXI4-Lite write address
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // AXI4-Lite write response
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  // AXI4-Lite read data
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // Supply detection and power down from the rest of the transceiver
  input  wire pac_pkg::pac_supply_t    i_supply_detected,
  input  wire logic                    i_std_power_down,
  // Analog configuration and power state
  output pac_pkg::pac_analog_cfg_t     o_analog_cfg,
  output logic                         o_deep_power_down,
  output logic                         o_deep_exiting,
  // Idle test pattern to the transmitter
  output logic                         o_idle_pattern_en,
  output logic                         o_idle_pattern_bit
);

  localparam int unsigned WAKE_W = 23;

  initial begin
    if (ADDR_W < 16 || ADDR_W > 32) begin
      $error("ADDR_W must cover the register map");
    end
    if (EXIT_FAST_N < 1 || EXIT_SLOW_N < 1 || EXIT_SLOW_N >= (1 << WAKE_W)) begin
      $error("Exit counts out of range");
    end
  end

  // Map a word index onto a storage slot
  function automatic logic [4:0] decode_slot(input logic [13:0] idx);
    logic [4:0] res;
    res = {1'b0, 4'h0};
    unique case (idx)
      pac_pkg::IDX_LINE_DRIVER_CLASS:  res = {1'b1, pac_pkg::SLOT_LDC};
      pac_pkg::IDX_ENERGY_THRESHOLD:   res = {1'b1, pac_pkg::SLOT_THR};
      pac_pkg::IDX_DC_CORRECTION:      res = {1'b1, pac_pkg::SLOT_DC};
      pac_pkg::IDX_FILTER_CONTROL_ONE: res = {1'b1, pac_pkg::SLOT_FILT};
      pac_pkg::IDX_EQUALIZER_CONTROL:  res = {1'b1, pac_pkg::SLOT_EQ};
      pac_pkg::IDX_SUPPLY_OVERRIDE:    res = {1'b1, pac_pkg::SLOT_SOVR};
      pac_pkg::IDX_SUPPLY_STATUS:      res = {1'b1, pac_pkg::SLOT_SSTAT};
      pac_pkg::IDX_DEEP_SLEEP_CONTROL: res = {1'b1, pac_pkg::SLOT_DSC};
      pac_pkg::IDX_DSP_CONFIG_SIX:     res = {1'b1, pac_pkg::SLOT_DSP6};
      pac_pkg::IDX_IDLE_PATTERN_LOW:   res = {1'b1, pac_pkg::SLOT_IDLE};
      default:                         res = {1'b0, 4'h0};
    endcase
    return res;
  endfunction

  // Reset value of each slot
  function automatic logic [15:0] slot_reset(input int unsigned s);
    logic [15:0] v;
    v = 16'h0000;
    case (s)
      0:       v = pac_pkg::RST_LDC;
      1:       v = pac_pkg::RST_THR;
      2:       v = pac_pkg::RST_DC;
      3:       v = pac_pkg::RST_FILT;
      4:       v = pac_pkg::RST_EQ;
      5:       v = pac_pkg::RST_SOVR;
      7:       v = pac_pkg::RST_DSC;
      8:       v = pac_pkg::RST_DSP6;
      9:       v = pac_pkg::RST_IDLE;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Bits that software may change in each slot
  function automatic logic [15:0] slot_wmask(input int unsigned s);
    logic [15:0] m;
    m = pac_pkg::WMASK_ALL;
    case (s)
      6:       m = pac_pkg::WMASK_NONE;
      7:       m = pac_pkg::WMASK_DSC;
      9:       m = pac_pkg::WMASK_IDLE;
      default: m = pac_pkg::WMASK_ALL;
    endcase
    return m;
  endfunction

  // Bus channel holding registers and register storage
  logic              aw_full_r;
  logic [13:0]       aw_idx_r;
  logic              w_full_r;
  logic [15:0]       w_data_r;
  logic [1:0]        w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic [15:0]       regs_r [pac_pkg::NUM_SLOTS];

  // Handshakes: each address or data beat is held until the pair completes
  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready  = !w_full_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  wire         aw_take  = s_axi_awvalid && s_axi_awready;
  wire         w_take   = s_axi_wvalid && s_axi_wready;
  wire         ar_take  = s_axi_arvalid && s_axi_arready;
  wire         wr_fire  = aw_full_r && w_full_r && !bvalid_r;
  wire [4:0]   wr_dec   = decode_slot(aw_idx_r);
  wire         wr_hit   = wr_dec[4];
  wire [3:0]   wr_slot  = wr_dec[3:0];
  wire [13:0]  ar_idx   = s_axi_araddr[15:2];
  wire [4:0]   rd_dec   = decode_slot(ar_idx);
  wire [15:0]  wr_bmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // Address and data beats may arrive in either order
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aw_full_r <= 1'b0;
      aw_idx_r  <= 14'h0000;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      aw_idx_r  <= s_axi_awaddr[15:2];
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      w_full_r <= 1'b0;
      w_data_r <= 16'h0000;
      w_strb_r <= 2'h0;
    end else if (w_take) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata[15:0];
      w_strb_r <= s_axi_wstrb[1:0];
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end
  end

  // Response follows the write one cycle after both beats are in
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= pac_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? pac_pkg::RESP_OKAY : pac_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Register storage; read-only bits never change, reserved RW bits keep writes
  for (genvar s = 0; s < pac_pkg::NUM_SLOTS; s++) begin : g_slot
    localparam logic [15:0] WM = slot_wmask(s);
    wire sel = wr_fire && wr_hit && (wr_slot == 4'(s));
    always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
        regs_r[s] <= slot_reset(s);
      end else if (sel) begin
        regs_r[s] <= (regs_r[s] & ~(WM & wr_bmask)) | (w_data_r & WM & wr_bmask);
      end
    end
  end

  // Effective supply levels: override wins over detection
  pac_pkg::pac_supply_t supply_eff;
  wire [15:0] sovr_w = regs_r[pac_pkg::SLOT_SOVR];
  assign supply_eff.core_3v3 = sovr_w[pac_pkg::SOVR_CORE_BIT] |
                               i_supply_detected.core_3v3;
  assign supply_eff.io_level =
      (sovr_w[pac_pkg::SOVR_IO_LSB +: 2] == pac_pkg::IO_FORCE_3V3) ?
      pac_pkg::IO_LEVEL_3V3 : i_supply_detected.io_level;

  // Read-only status view
  wire [15:0] status_w = {13'h0000, supply_eff.core_3v3, supply_eff.io_level};

  wire [15:0] rd_word = (rd_dec[3:0] == pac_pkg::SLOT_SSTAT) ? status_w :
                        regs_r[rd_dec[3:0]];

  // Read answer one cycle after the address is taken; unmapped reads zero
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= pac_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_dec[4] ? {16'h0000, rd_word} : 32'h0000_0000;
      rresp_r  <= rd_dec[4] ? pac_pkg::RESP_OKAY : pac_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Analog configuration decode
  wire [15:0] dsc_w = regs_r[pac_pkg::SLOT_DSC];
  assign o_analog_cfg.class_a =
      (regs_r[pac_pkg::SLOT_LDC] == pac_pkg::LDC_CLASS_A);
  assign o_analog_cfg.energy_threshold =
      regs_r[pac_pkg::SLOT_THR][pac_pkg::THR_LSB +: 5];
  assign o_analog_cfg.fixed_dc =
      regs_r[pac_pkg::SLOT_DC][pac_pkg::DC_FIXED_BIT];
  assign o_analog_cfg.filter_cutoff =
      regs_r[pac_pkg::SLOT_FILT][pac_pkg::FILT_LSB +: 5];
  assign o_analog_cfg.equalizer =
      regs_r[pac_pkg::SLOT_EQ][pac_pkg::EQ_LSB +: 6];
  assign o_analog_cfg.core_force_3v3 = sovr_w[pac_pkg::SOVR_CORE_BIT];
  assign o_analog_cfg.io_force_3v3 =
      (sovr_w[pac_pkg::SOVR_IO_LSB +: 2] == pac_pkg::IO_FORCE_3V3);
  assign o_analog_cfg.eq_cal_bypass =
      regs_r[pac_pkg::SLOT_DSP6][pac_pkg::DSP6_EQ_BYPASS_BIT];

  // Deep power down sequencer
  pac_pkg::pac_sleep_state_t sleep_r;
  pac_pkg::pac_sleep_state_t sleep_nxt;
  logic [WAKE_W-1:0]         wake_cnt_r;
  logic [WAKE_W-1:0]         wake_cnt_nxt;

  wire deep_req  = dsc_w[pac_pkg::DSC_DEEP_EN_BIT];
  wire fast_exit = dsc_w[pac_pkg::DSC_FAST_EXIT_BIT];
  wire [WAKE_W-1:0] exit_load = fast_exit ? WAKE_W'(EXIT_FAST_N - 1) :
                                            WAKE_W'(EXIT_SLOW_N - 1);

  // Deep sleep is entered from awake only on top of standard power down; a request while waking re-enters it directly
  always_comb begin
    sleep_nxt    = sleep_r;
    wake_cnt_nxt = wake_cnt_r;
    unique case (sleep_r)
      pac_pkg::PAC_AWAKE: begin
        if (deep_req && i_std_power_down) begin
          sleep_nxt = pac_pkg::PAC_ASLEEP;
        end
      end
      pac_pkg::PAC_ASLEEP: begin
        if (!deep_req) begin
          sleep_nxt    = pac_pkg::PAC_WAKING;
          wake_cnt_nxt = exit_load;
        end
      end
      pac_pkg::PAC_WAKING: begin
        if (deep_req) begin
          sleep_nxt = pac_pkg::PAC_ASLEEP;
        end else if (wake_cnt_r == '0) begin
          sleep_nxt = pac_pkg::PAC_AWAKE;
        end else begin
          wake_cnt_nxt = wake_cnt_r - WAKE_W'(1);
        end
      end
      default: begin
        sleep_nxt = pac_pkg::PAC_AWAKE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sleep_r    <= pac_pkg::PAC_AWAKE;
      wake_cnt_r <= '0;
    end else begin
      sleep_r    <= sleep_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  assign o_deep_power_down = (sleep_r == pac_pkg::PAC_ASLEEP);
  assign o_deep_exiting    = (sleep_r == pac_pkg::PAC_WAKING);

  // Idle test pattern: a one followed by N zeros, repeating
  wire [4:0] idle_count = {dsc_w[pac_pkg::DSC_IDLE_MSB_BIT],
                           regs_r[pac_pkg::SLOT_IDLE][3:0]};
  wire       idle_en    = dsc_w[pac_pkg::DSC_IDLE_EN_BIT];
  logic [4:0] zero_cnt_r;
  logic       idle_bit_r;

  // Zero count clears the shifter so no stale pattern leaks out
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      zero_cnt_r <= 5'h00;
      idle_bit_r <= 1'b0;
    end else if (!idle_en || idle_count == 5'h00) begin
      zero_cnt_r <= 5'h00;
      idle_bit_r <= 1'b0;
    end else if (zero_cnt_r == 5'h00) begin
      zero_cnt_r <= idle_count;
      idle_bit_r <= 1'b1;
    end else begin
      zero_cnt_r <= zero_cnt_r - 5'h01;
      idle_bit_r <= 1'b0;
    end
  end

  assign o_idle_pattern_en  = idle_en;
  assign o_idle_pattern_bit = idle_bit_r;

endmodule

// *** tb/pac_regs_checker.sv ***
`timescale 1ns/1ns
// Port-level checks on bus timing, sleep sequencing and the idle pattern
module pac_regs_checker #(
  parameter int unsigned ADDR_W      = 16,
  parameter int unsigned EXIT_FAST_N = 20,
  parameter int unsigned EXIT_SLOW_N = 40
) (
  // Clock and reset
  input wire logic                     i_clock,
  input wire logic                     i_rst,
  // Register bus
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic [ADDR_W-1:0]        s_axi_awaddr,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic [31:0]              s_axi_wdata,
  input wire logic [3:0]               s_axi_wstrb,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [ADDR_W-1:0]        s_axi_araddr,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic [1:0]               s_axi_rresp,
  // Transceiver side
  input wire pac_pkg::pac_supply_t     i_supply_detected,
  input wire logic                     i_std_power_down,
  input wire pac_pkg::pac_analog_cfg_t o_analog_cfg,
  input wire logic                     o_deep_power_down,
  input wire logic                     o_deep_exiting,
  input wire logic                     o_idle_pattern_en,
  input wire logic                     o_idle_pattern_bit
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  logic [31:0] exit_cnt_r;
  logic [31:0] exit_cnt_nxt;

  // Length of the exit interval so far; cleared whenever the flag drops
  assign exit_cnt_nxt = o_deep_exiting ? exit_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      exit_cnt_r <= 32'h0;
    end else begin
      exit_cnt_r <= exit_cnt_nxt;
    end
  end

  // Both write beats taken at one edge
  sequence seq_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Response held back one cycle, then raised
  sequence seq_resp_two;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  // Pattern mode off for two samples, long enough for the register stage
  sequence seq_idle_off;
    !o_idle_pattern_en [*2];
  endsequence

  chk_wr_latency: assert property (seq_wr_both |=> seq_resp_two)
    else $error("write response timing wrong");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_sleep_gate: assert property ($rose(o_deep_power_down) && !$past(o_deep_exiting) |->
    $past(i_std_power_down)) else $error("deep sleep entered without power down");
  chk_exit_excl: assert property (o_deep_exiting |-> !o_deep_power_down)
    else $error("exiting while asleep");
  chk_exit_length: assert property ($fell(o_deep_exiting) && !o_deep_power_down |->
    exit_cnt_r == EXIT_FAST_N || exit_cnt_r == EXIT_SLOW_N) else $error("exit interval length");
  chk_idle_quiet: assert property (seq_idle_off |-> !o_idle_pattern_bit)
    else $error("pattern bit with mode off");
endmodule

bind pac_regs pac_regs_checker #(.ADDR_W(ADDR_W), .EXIT_FAST_N(EXIT_FAST_N),
  .EXIT_SLOW_N(EXIT_SLOW_N)) u_chk (.i_clock, .i_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .i_supply_detected, .i_std_power_down,
  .o_analog_cfg, .o_deep_power_down, .o_deep_exiting, .o_idle_pattern_en, .o_idle_pattern_bit);

// *** tb/pac_regs_tb_top.sv ***
`timescale 1ns/1ns
// Self-checking bench for the analog and power configuration registers
module pac_regs_tb_top;
  // Short exit counts keep the run brief
  localparam int unsigned FAST_N = 20;
  localparam int unsigned SLOW_N = 40;
  typedef struct packed {
    logic [13:0] idx;
    logic [15:0] rst_val;
    logic [15:0] wr_val;
    logic [15:0] exp_val;
  } pac_row_t;
  logic                     i_clock           = 1'b0;
  logic                     i_rst             = 1'b1;
  logic                     s_axi_awvalid     = 1'b0;
  logic [15:0]              s_axi_awaddr      = 16'h0000;
  logic                     s_axi_wvalid      = 1'b0;
  logic [31:0]              s_axi_wdata       = 32'h00000000;
  logic [3:0]               s_axi_wstrb       = 4'h0;
  logic                     s_axi_bready      = 1'b0;
  logic                     s_axi_arvalid     = 1'b0;
  logic [15:0]              s_axi_araddr      = 16'h0000;
  logic                     s_axi_rready      = 1'b0;
  logic                     i_std_power_down  = 1'b0;
  pac_pkg::pac_supply_t     i_supply_detected = 3'h1;
  logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]               s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0]              s_axi_rdata, rd;
  pac_pkg::pac_analog_cfg_t o_analog_cfg;
  logic                     o_deep_power_down, o_deep_exiting, o_idle_pattern_en, o_idle_pattern_bit;
  logic [4:0]               c;
  int                       error_cnt = 0;
  int                       n_tests   = 0;
  int                       cnt;
  int                       cs [4]    = '{1, 3, 17, 31};
  // Index, reset value, value written, value read back
  pac_row_t rows [10] = '{'{14'h0404, 16'h0020, 16'h0024, 16'h0024},
    '{14'h040D, 16'h0008, 16'hFFFF, 16'hFFFF}, '{14'h0410, 16'h2000, 16'h4000, 16'h4000},
    '{14'h0416, 16'h0870, 16'h1F00, 16'h1F00}, '{14'h0418, 16'h0000, 16'h3F00, 16'h3F00},
    '{14'h0421, 16'h0001, 16'hFFFF, 16'h0001}, '{14'h041F, 16'h0000, 16'h1C00, 16'h1C00},
    '{14'h0428, 16'h0000, 16'hFFC0, 16'h0000}, '{14'h0450, 16'h0141, 16'h2000, 16'h2000},
    '{14'h0027, 16'h0000, 16'hFFF5, 16'h0005}};

  // Free-running 25 MHz clock
  always #20 i_clock = ~i_clock;

  pac_regs #(.ADDR_W(16), .EXIT_FAST_N(FAST_N), .EXIT_SLOW_N(SLOW_N)) uut (.i_clock, .i_rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .i_supply_detected,
    .i_std_power_down, .o_analog_cfg, .o_deep_power_down, .o_deep_exiting, .o_idle_pattern_en,
    .o_idle_pattern_bit);

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [13:0] idx, input logic [15:0] d, input logic [1:0] st,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clock);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= {2'b00, st};
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask

  // Read address dropped once taken, ready held until the answer is sampled
  task automatic rd_t(input logic [13:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask

  // Bounded wait for the exit flag, then its length in cycles
  task automatic meas_exit(output int n);
    int k;
    k = 0;
    n = 0;
    while (!o_deep_exiting && k < 10) begin
      @(posedge i_clock);
      k++;
    end
    while (o_deep_exiting && n < 100) begin
      @(posedge i_clock);
      n++;
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    cmp_reg({11'h000, o_analog_cfg}, 32'h00041000);
    foreach (rows[i]) begin
      rd_t(rows[i].idx, rd, rsp);
      cmp_reg(rd, {16'h0000, rows[i].rst_val});
      wr(rows[i].idx, rows[i].wr_val, 2'b11, rsp);
      cmp_resp(rsp, pac_pkg::RESP_OKAY);
      rd_t(rows[i].idx, rd, rsp);
      cmp_reg(rd, {16'h0000, rows[i].exp_val});
    end
    cmp_reg({11'h000, o_analog_cfg}, 32'h001FFFFF);
    // Both overrides now set, so status shows the forced levels
    rd_t(14'h0421, rd, rsp);
    cmp_reg(rd, 32'h00000007);
    $display("test done: register table");
    // Low byte only: back to class B
    wr(14'h0404, 16'hFF20, 2'b01, rsp);
    rd_t(14'h0404, rd, rsp);
    cmp_reg(rd, 32'h00000020);
    cmp_reg({31'h0, o_analog_cfg.class_a}, 32'h0);
    wr(14'h0405, 16'hFFFF, 2'b11, rsp);
    cmp_resp(rsp, pac_pkg::RESP_SLVERR);
    rd_t(14'h0405, rd, rsp);
    cmp_reg(rd, 32'h0);
    cmp_resp(rsp, pac_pkg::RESP_SLVERR);
    $display("test done: strobes and unmapped");
    // Deep sleep waits for standard power down, then both exit lengths
    wr(14'h0428, 16'h0004, 2'b11, rsp);
    repeat (5) @(posedge i_clock);
    cmp_reg({31'h0, o_deep_power_down}, 32'h0);
    i_std_power_down <= 1'b1;
    repeat (3) @(posedge i_clock);
    cmp_reg({31'h0, o_deep_power_down}, 32'h1);
    wr(14'h0428, 16'h0008, 2'b11, rsp);
    meas_exit(cnt);
    cmp_reg(cnt, FAST_N);
    wr(14'h0428, 16'h0004, 2'b11, rsp);
    repeat (3) @(posedge i_clock);
    cmp_reg({31'h0, o_deep_power_down}, 32'h1);
    wr(14'h0428, 16'h0000, 2'b11, rsp);
    meas_exit(cnt);
    cmp_reg(cnt, SLOW_N);
    cmp_reg({31'h0, o_deep_power_down}, 32'h0);
    $display("test done: deep sleep");
    // Idle pattern: a one followed by exactly c zeros, top bit from the control register
    foreach (cs[k]) begin
      c = 5'(cs[k]);
      wr(14'h0428, 16'h0000, 2'b11, rsp);
      wr(14'h0027, {12'h000, c[3:0]}, 2'b11, rsp);
      wr(14'h0428, {10'h000, c[4], 5'h10}, 2'b11, rsp);
      cmp_reg({31'h0, o_idle_pattern_en}, 32'h1);
      cnt = 0;
      while (!o_idle_pattern_bit && cnt < 40) begin
        @(posedge i_clock);
        cnt++;
      end
      rd = 32'h0;
      repeat (int'(c) + 1) begin
        @(posedge i_clock);
        rd = {rd[30:0], o_idle_pattern_bit};
      end
      cmp_reg(rd, 32'h00000001);
    end
    // Count zero keeps the line quiet
    wr(14'h0428, 16'h0000, 2'b11, rsp);
    wr(14'h0027, 16'h0000, 2'b11, rsp);
    wr(14'h0428, 16'h0010, 2'b11, rsp);
    rd = 32'h0;
    repeat (40) begin
      @(posedge i_clock);
      rd[0] = rd[0] | o_idle_pattern_bit;
    end
    cmp_reg(rd, 32'h0);
    $display("test done: idle pattern");
    // Mid-run reset returns the map and the pattern mode to reset state
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    rd_t(14'h0404, rd, rsp);
    cmp_reg(rd, 32'h00000020);
    cmp_reg({31'h0, o_idle_pattern_en}, 32'h0);
    $display("test done: reset");
    close_out();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    close_out();
  end
endmodule
